// File: rtl/fund_energy_pkg.sv
// How it works
// - Low-range gain applies only while the current amplifier sits at gain 32.
// - Effective low-range gain is the stored coefficient divided by 2^14.
// - Low-range offset is signed 16 bits, added to current, resets to zero.
// - Form 0 uses sqrt of rms^2 plus offset*2^16; form 1 uses rms plus offset.
// - Auxiliary channel 32-bit RMS result lands in the on-demand RMS register.
// - Flag byte: apparent 4, react neg 3, react pos 2, real neg 1, real pos 0.
// - A set overflow flag stays set until the host clears it.
// - Positive cycle real energy adds to real positive total; overflow sets bit 0.
// - Negative cycle real energy magnitude adds to real negative total; bit 1.
// - Real energy totals are 32 bits and wrap around on overflow.
// - Positive cycle reactive energy adds to reactive positive total; bit 2.
// - Negative cycle reactive magnitude adds to reactive negative total; bit 3.
// - Apparent energy, or current in low power, adds to apparent total; bit 4.
`default_nettype none
package fund_energy_pkg;
    localparam int NUM_PHASES = 3;
    localparam int ADDR_W = 12;
    localparam int GAIN_FRAC_BITS = 14;
    localparam int OFFS_SCALE_BITS = 16;
    localparam logic [ADDR_W-1:0] AUX_RMS_RESULT_OFS = 12'h11c;
    localparam logic [ADDR_W-1:0] LOW_RANGE_GAIN_OFS [NUM_PHASES] = '{12'h13a, 12'h226, 12'h312};
    localparam logic [ADDR_W-1:0] LOW_RANGE_OFFSET_OFS [NUM_PHASES] = '{12'h13c, 12'h228, 12'h314};
    localparam logic [ADDR_W-1:0] FUND_OVF_FLAGS_OFS [NUM_PHASES] = '{12'h147, 12'h233, 12'h31f};
    localparam logic [ADDR_W-1:0] FUND_REAL_POS_OFS [NUM_PHASES] = '{12'h1fc, 12'h2e8, 12'h3d4};
    localparam logic [ADDR_W-1:0] FUND_REAL_NEG_OFS [NUM_PHASES] = '{12'h200, 12'h2fc, 12'h3d8};
    localparam logic [15:0] LOW_RANGE_GAIN_RST = 16'h4000;
    localparam logic [15:0] LOW_RANGE_OFFSET_RST = 16'h0000;
    localparam logic [7:0] FUND_OVF_FLAGS_RST = 8'h00;
    localparam logic [31:0] ENERGY_RST = 32'h0000_0000;
    localparam logic [31:0] AUX_RMS_RST = 32'h0000_0000;
    localparam int REAL_POS_OVF_BIT = 0;
    localparam int REAL_NEG_OVF_BIT = 1;
    localparam int REACTIVE_POS_OVF_BIT = 2;
    localparam int REACTIVE_NEG_OVF_BIT = 3;
    localparam int APPARENT_OVF_BIT = 4;
    localparam logic [7:0] FLAG_USED_MASK = 8'h1f;

    typedef struct packed {
        logic signed [31:0] real_energy;
        logic signed [31:0] reactive_energy;
        logic [31:0] apparent_energy;
        logic [31:0] current_value;
    } cycle_energy_t;

    typedef struct packed {
        logic [31:0] rms_current_value;
        logic pga_gain32;
    } current_meas_t;

    typedef struct packed {
        logic [31:0] fund_real_pos_energy;
        logic [31:0] fund_real_neg_energy;
        logic [31:0] fund_reactive_pos_energy;
        logic [31:0] fund_reactive_neg_energy;
        logic [31:0] fund_apparent_energy;
    } energy_bank_t;
endpackage : fund_energy_pkg
`default_nettype wire

// File: rtl/phase_energy_accum.sv
`timescale 1ns/1ps
`default_nettype none
module phase_energy_accum
    import fund_energy_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic dsp_cycle_in,
    input wire logic low_power_in,
    input wire cycle_energy_t cycle_in,
    input wire logic [7:0] flag_clear_in,
    output energy_bank_t bank_out,
    output logic [7:0] fund_overflow_flags_out
);
    energy_bank_t bank;
    energy_bank_t next_bank;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic [4:0] carry;
    logic [31:0] real_mag;
    logic [31:0] react_mag;
    logic [31:0] app_add;

    always_comb begin
        next_bank = bank;
        carry = 5'h00;
        real_mag = 32'(-cycle_in.real_energy);
        react_mag = 32'(-cycle_in.reactive_energy);
        app_add = low_power_in ? cycle_in.current_value : cycle_in.apparent_energy;
        if (dsp_cycle_in) begin
            if (cycle_in.real_energy > 0) begin
                {carry[REAL_POS_OVF_BIT], next_bank.fund_real_pos_energy} =
                    {1'b0, bank.fund_real_pos_energy} + {1'b0, cycle_in.real_energy};
            end else if (cycle_in.real_energy < 0) begin
                {carry[REAL_NEG_OVF_BIT], next_bank.fund_real_neg_energy} =
                    {1'b0, bank.fund_real_neg_energy} + {1'b0, real_mag};
            end
            if (cycle_in.reactive_energy > 0) begin
                {carry[REACTIVE_POS_OVF_BIT], next_bank.fund_reactive_pos_energy} =
                    {1'b0, bank.fund_reactive_pos_energy} + {1'b0, cycle_in.reactive_energy};
            end else if (cycle_in.reactive_energy < 0) begin
                {carry[REACTIVE_NEG_OVF_BIT], next_bank.fund_reactive_neg_energy} =
                    {1'b0, bank.fund_reactive_neg_energy} + {1'b0, react_mag};
            end
            {carry[APPARENT_OVF_BIT], next_bank.fund_apparent_energy} =
                {1'b0, bank.fund_apparent_energy} + {1'b0, app_add};
        end
        // Set beats clear in the same cycle so no overflow is lost
        next_flags = ((flags & ~flag_clear_in) | {3'b000, carry}) & FLAG_USED_MASK;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bank <= '{default: ENERGY_RST};
            flags <= FUND_OVF_FLAGS_RST;
        end else begin
            bank <= next_bank;
            flags <= next_flags;
        end
    end

    assign bank_out = bank;
    assign fund_overflow_flags_out = flags;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_real_pos_add: assert property (
        dsp_cycle_in && cycle_in.real_energy > 0 |=>
        bank.fund_real_pos_energy == 32'($past(bank.fund_real_pos_energy)
            + $past(cycle_in.real_energy)))
        else $error("real positive total did not add cycle energy");
    a_real_neg_add: assert property (
        dsp_cycle_in && cycle_in.real_energy < 0 |=>
        bank.fund_real_neg_energy == 32'($past(bank.fund_real_neg_energy)
            - $past(cycle_in.real_energy)))
        else $error("real negative total did not add magnitude");
    a_zero_real_hold: assert property (
        dsp_cycle_in && cycle_in.real_energy == 0 && flag_clear_in[1:0] == 2'b00 |=>
        $stable(bank.fund_real_pos_energy) && $stable(bank.fund_real_neg_energy)
        && $stable(flags[1:0]))
        else $error("zero real energy changed real totals");
    a_wrap_sets_flag: assert property (
        dsp_cycle_in && cycle_in.real_energy > 0 &&
        ({1'b0, bank.fund_real_pos_energy} + {1'b0, cycle_in.real_energy}) > 33'hffff_ffff
        |=> flags[REAL_POS_OVF_BIT] &&
        bank.fund_real_pos_energy < $past(bank.fund_real_pos_energy))
        else $error("real positive wrap did not flag");
    a_flag_sticky: assert property (
        flags[APPARENT_OVF_BIT] && !flag_clear_in[APPARENT_OVF_BIT] |=> flags[APPARENT_OVF_BIT])
        else $error("apparent flag dropped without host clear");
    a_no_cycle_hold: assert property (
        !dsp_cycle_in |=> $stable(bank))
        else $error("totals moved outside a DSP cycle");
    a_lowpower_amp_hours: assert property (
        dsp_cycle_in && low_power_in |=> bank.fund_apparent_energy ==
            32'($past(bank.fund_apparent_energy) + $past(cycle_in.current_value)))
        else $error("low power did not accumulate current");
    c_real_wrap: cover property (dsp_cycle_in && carry[REAL_POS_OVF_BIT]);
    c_set_and_clear: cover property (|carry && |(flag_clear_in & {3'b000, carry}));
endmodule : phase_energy_accum
`default_nettype wire

// File: rtl/fund_energy_regs.sv
`timescale 1ns/1ps
`default_nettype none
module fund_energy_regs
    import fund_energy_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic reg_err_out,
    input wire logic dsp_cycle_in,
    input wire logic low_power_in,
    input wire logic linearity_form_select_in,
    input wire cycle_energy_t cycle_in [NUM_PHASES],
    input wire current_meas_t meas_in [NUM_PHASES],
    input wire logic aux_rms_valid_in,
    input wire logic [31:0] aux_rms_in,
    output logic [31:0] corrected_current_out [NUM_PHASES],
    output logic corrected_valid_out
);
    logic [15:0] low_range_gain_coeff [NUM_PHASES];
    logic [15:0] next_low_range_gain_coeff [NUM_PHASES];
    logic [15:0] low_range_offset [NUM_PHASES];
    logic [15:0] next_low_range_offset [NUM_PHASES];
    logic [31:0] aux_rms_result;
    logic [31:0] next_aux_rms_result;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic ack;
    logic next_ack;
    logic err;
    logic next_err;
    logic [7:0] flag_clear [NUM_PHASES];
    energy_bank_t bank [NUM_PHASES];
    logic [7:0] fund_overflow_flags [NUM_PHASES];
    logic [31:0] corrected [NUM_PHASES];
    logic [31:0] next_corrected [NUM_PHASES];
    logic corr_valid;
    logic next_corr_valid;

    // Bit-by-bit root; wide but purely combinational, one result per cycle
    function automatic logic [31:0] isqrt64(input logic [63:0] v);
        logic [31:0] root;
        logic [31:0] cand;
        root = 32'h0000_0000;
        for (int i = 31; i >= 0; i--) begin
            cand = root | (32'h0000_0001 << i);
            if ({32'h0000_0000, cand} * {32'h0000_0000, cand} <= {64'h0, v}) begin
                root = cand;
            end
        end
        return root;
    endfunction : isqrt64

    function automatic logic [31:0] compensate(input logic [31:0] rms, input logic [15:0] gain,
                                               input logic [15:0] offs, input logic form);
        logic signed [65:0] rad;
        logic signed [33:0] lin;
        logic [63:0] rad_sat;
        logic [32:0] base;
        logic [48:0] prod;
        logic [34:0] scaled;
        rad = $signed({2'b00, 64'(rms) * 64'(rms)})
              + ($signed(66'(signed'(offs))) <<< OFFS_SCALE_BITS);
        lin = $signed({2'b00, rms}) + $signed(34'(signed'(offs)));
        if (rad < 0) begin
            rad_sat = 64'h0;
        end else if (rad[65:64] != 2'b00) begin
            rad_sat = '1;
        end else begin
            rad_sat = rad[63:0];
        end
        if (form) begin
            base = (lin < 0) ? 33'h0 : lin[32:0];
        end else begin
            base = {1'b0, isqrt64(rad_sat)};
        end
        prod = 49'(gain) * 49'(base);
        scaled = prod[48:GAIN_FRAC_BITS];
        // Saturate rather than wrap; a wrapped current would read as near zero
        return (scaled[34:32] != 3'b000) ? 32'hffff_ffff : scaled[31:0];
    endfunction : compensate

    // Register writes and reads
    always_comb begin
        next_low_range_gain_coeff = low_range_gain_coeff;
        next_low_range_offset = low_range_offset;
        next_aux_rms_result = aux_rms_valid_in ? aux_rms_in : aux_rms_result;
        next_rdata = rdata;
        next_ack = reg_wr_in || reg_rd_in;
        next_err = 1'b0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            flag_clear[p] = 8'h00;
        end
        if (reg_wr_in) begin
            next_err = 1'b1;
            for (int p = 0; p < NUM_PHASES; p++) begin
                if (reg_addr_in == LOW_RANGE_GAIN_OFS[p]) begin
                    next_low_range_gain_coeff[p] = reg_wdata_in[15:0];
                    next_err = 1'b0;
                end
                if (reg_addr_in == LOW_RANGE_OFFSET_OFS[p]) begin
                    next_low_range_offset[p] = reg_wdata_in[15:0];
                    next_err = 1'b0;
                end
                if (reg_addr_in == FUND_OVF_FLAGS_OFS[p]) begin
                    // Write one to clear; only the host ever clears a flag
                    flag_clear[p] = reg_wdata_in[7:0] & FLAG_USED_MASK;
                    next_err = 1'b0;
                end
                if (reg_addr_in == FUND_REAL_POS_OFS[p] || reg_addr_in == FUND_REAL_NEG_OFS[p]) begin
                    next_err = 1'b0;
                end
            end
            if (reg_addr_in == AUX_RMS_RESULT_OFS) begin
                next_err = 1'b0;
            end
        end else if (reg_rd_in) begin
            next_rdata = 32'h0000_0000;
            next_err = 1'b1;
            if (reg_addr_in == AUX_RMS_RESULT_OFS) begin
                next_rdata = aux_rms_result;
                next_err = 1'b0;
            end
            for (int p = 0; p < NUM_PHASES; p++) begin
                if (reg_addr_in == LOW_RANGE_GAIN_OFS[p]) begin
                    next_rdata = {16'h0000, low_range_gain_coeff[p]};
                    next_err = 1'b0;
                end
                if (reg_addr_in == LOW_RANGE_OFFSET_OFS[p]) begin
                    next_rdata = {16'h0000, low_range_offset[p]};
                    next_err = 1'b0;
                end
                if (reg_addr_in == FUND_OVF_FLAGS_OFS[p]) begin
                    next_rdata = {24'h00_0000, fund_overflow_flags[p]};
                    next_err = 1'b0;
                end
                if (reg_addr_in == FUND_REAL_POS_OFS[p]) begin
                    next_rdata = bank[p].fund_real_pos_energy;
                    next_err = 1'b0;
                end
                if (reg_addr_in == FUND_REAL_NEG_OFS[p]) begin
                    next_rdata = bank[p].fund_real_neg_energy;
                    next_err = 1'b0;
                end
            end
        end
    end

    // Linearity compensation, refreshed once per DSP cycle
    always_comb begin
        next_corrected = corrected;
        next_corr_valid = dsp_cycle_in;
        if (dsp_cycle_in) begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                if (meas_in[p].pga_gain32) begin
                    next_corrected[p] = compensate(meas_in[p].rms_current_value,
                        low_range_gain_coeff[p], low_range_offset[p], linearity_form_select_in);
                end else begin
                    next_corrected[p] = meas_in[p].rms_current_value;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            low_range_gain_coeff <= '{default: LOW_RANGE_GAIN_RST};
            low_range_offset <= '{default: LOW_RANGE_OFFSET_RST};
            aux_rms_result <= AUX_RMS_RST;
            rdata <= 32'h0000_0000;
            ack <= 1'b0;
            err <= 1'b0;
            corrected <= '{default: 32'h0000_0000};
            corr_valid <= 1'b0;
        end else begin
            low_range_gain_coeff <= next_low_range_gain_coeff;
            low_range_offset <= next_low_range_offset;
            aux_rms_result <= next_aux_rms_result;
            rdata <= next_rdata;
            ack <= next_ack;
            err <= next_err;
            corrected <= next_corrected;
            corr_valid <= next_corr_valid;
        end
    end

    for (genvar g = 0; g < NUM_PHASES; g++) begin : g_phase
        phase_energy_accum u_accum (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .dsp_cycle_in(dsp_cycle_in),
            .low_power_in(low_power_in),
            .cycle_in(cycle_in[g]),
            .flag_clear_in(flag_clear[g]),
            .bank_out(bank[g]),
            .fund_overflow_flags_out(fund_overflow_flags[g])
        );
    end

    assign reg_rdata_out = rdata;
    assign reg_ack_out = ack;
    assign reg_err_out = err;
    assign corrected_current_out = corrected;
    assign corrected_valid_out = corr_valid;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_flags_reserved_zero: assert property (
        ##1 (fund_overflow_flags[0][7:5] == 3'b000 && fund_overflow_flags[1][7:5] == 3'b000
             && fund_overflow_flags[2][7:5] == 3'b000))
        else $error("reserved flag bits not zero");
    a_flag_clear_host: assert property (
        reg_wr_in && reg_addr_in == FUND_OVF_FLAGS_OFS[0] && reg_wdata_in[0]
        && !(dsp_cycle_in && cycle_in[0].real_energy > 0)
        |=> !fund_overflow_flags[0][REAL_POS_OVF_BIT])
        else $error("host clear of real positive flag ignored");
    a_aux_rms_capture: assert property (
        aux_rms_valid_in ##1 !aux_rms_valid_in ##1 reg_rd_in && !reg_wr_in
        && reg_addr_in == AUX_RMS_RESULT_OFS && !aux_rms_valid_in
        |=> reg_ack_out && reg_rdata_out == $past(aux_rms_in, 3))
        else $error("aux RMS result not readable");
    a_high_range_bypass: assert property (
        dsp_cycle_in && !meas_in[1].pga_gain32 |=>
        corrected_current_out[1] == $past(meas_in[1].rms_current_value) && corrected_valid_out)
        else $error("gain applied outside low range");
    a_unity_form1: assert property (
        dsp_cycle_in && meas_in[0].pga_gain32 && linearity_form_select_in
        && low_range_gain_coeff[0] == 16'h4000 && low_range_offset[0] == 16'h0000
        |=> corrected_current_out[0] == $past(meas_in[0].rms_current_value))
        else $error("unity gain changed current");
    a_read_ack_timing: assert property (
        reg_rd_in && reg_addr_in == FUND_REAL_NEG_OFS[2] |=> reg_ack_out && !reg_err_out
        && reg_rdata_out == $past(bank[2].fund_real_neg_energy))
        else $error("real negative read wrong");
    c_low_range_form0: cover property (dsp_cycle_in && meas_in[0].pga_gain32
        && !linearity_form_select_in);
    c_flag_read_set: cover property (reg_rd_in && reg_addr_in == FUND_OVF_FLAGS_OFS[1]
        && fund_overflow_flags[1] != 8'h00);
    c_unmapped: cover property (reg_ack_out && reg_err_out);
endmodule : fund_energy_regs
`default_nettype wire

// File: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
    import fund_energy_pkg::*;
(
    input wire logic clk_in,
    output logic [ADDR_W-1:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [31:0] wdata_out,
    input wire logic [31:0] rdata_in,
    input wire logic ack_in,
    input wire logic err_in
);
    initial begin
        addr_out = '0;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = '0;
    end

    // One strobe cycle; answer read once the taking edge has settled
    task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic e, output logic k);
        @(posedge clk_in);
        addr_out <= a;
        wr_out <= w;
        rd_out <= ~w;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        wdata_out <= ~d;
        #1;
        q = rdata_in;
        e = err_in;
        k = ack_in;
    endtask : access

    // Flags are sticky in the device, so only the host removes them
    task automatic clear_flags(input int p, input logic [7:0] bits);
        logic [31:0] q;
        logic e;
        logic k;
        access(1'b1, FUND_OVF_FLAGS_OFS[p], {24'h0, bits}, q, e, k);
    endtask : clear_flags

    // Wrapped total needs one full turn added back
    function automatic logic [32:0] used(input logic [31:0] prev, input logic [31:0] cur,
                                         input logic ovf);
        return {1'b0, cur} - {1'b0, prev} + (ovf ? 33'h1_0000_0000 : 33'h0);
    endfunction : used
endmodule : host_model
`default_nettype wire

// File: tb/fund_energy_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, exp, got); end end
module fund_energy_regs_test
    import fund_energy_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic wr, rd, ack, err, dsp_cycle, low_power, form, aux_valid, corr_valid;
    logic [31:0] wdata, rdata, aux_rms, q;
    logic [31:0] corr [NUM_PHASES];
    cycle_energy_t cyc [NUM_PHASES];
    current_meas_t meas [NUM_PHASES];
    logic e, k;
    int n_mismatch = 0;
    int checks_done = 0;

    fund_energy_regs fund_energy_regs_i (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_ack_out(ack), .reg_err_out(err), .dsp_cycle_in(dsp_cycle),
        .low_power_in(low_power), .linearity_form_select_in(form), .cycle_in(cyc),
        .meas_in(meas), .aux_rms_valid_in(aux_valid), .aux_rms_in(aux_rms),
        .corrected_current_out(corr), .corrected_valid_out(corr_valid));
    host_model host_model_i (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .wdata_out(wdata), .rdata_in(rdata), .ack_in(ack), .err_in(err));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic close_out();
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] x, input string nm);
        host_model_i.access(1'b0, a, 32'h0, q, e, k);
        `CHK("ack", 1'b1, k)
        `CHK("err", 1'b0, e)
        `CHK(nm, x, q)
    endtask : rdc

    task automatic wrr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        host_model_i.access(1'b1, a, d, q, e, k);
    endtask : wrr

    task automatic dsp(input logic [31:0] re, input logic [31:0] ra, input logic [31:0] ap,
                       input logic [31:0] cu);
        @(posedge clk_in);
        for (int p = 0; p < NUM_PHASES; p++) begin
            cyc[p] <= '{re, ra, ap, cu};
        end
        dsp_cycle <= 1'b1;
        @(posedge clk_in);
        dsp_cycle <= 1'b0;
        #1;
    endtask : dsp

    task automatic chkf(input logic [31:0] x);
        for (int p = 0; p < NUM_PHASES; p++) begin
            rdc(FUND_OVF_FLAGS_OFS[p], x, "flags");
        end
    endtask : chkf

    task automatic ccur(input logic [31:0] x);
        dsp(32'h0, 32'h0, 32'h0, 32'h0);
        `CHK("valid", 1'b1, corr_valid)
        `CHK("corrected", x, corr[0])
    endtask : ccur

    initial begin
        {dsp_cycle, low_power, form, aux_valid, aux_rms} = '0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            cyc[p] = '0;
            meas[p] = '{32'd100, 1'b1};
        end
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            rdc(LOW_RANGE_OFFSET_OFS[p], 32'h0, "offs_rst");
            rdc(LOW_RANGE_GAIN_OFS[p], 32'h4000, "gain_rst");
        end
        chkf(32'h0);
        host_model_i.access(1'b0, 12'h0ff, 32'h0, q, e, k);
        `CHK("unmapped_err", 1'b1, e)
        `CHK("unmapped_data", 32'h0, q)
        dsp(32'h5, 32'h0, 32'h0, 32'h0);
        dsp(32'hffff_fff9, 32'h0, 32'h0, 32'h0);
        dsp(32'h0, 32'h0, 32'h0, 32'h0);
        wrr(FUND_REAL_POS_OFS[0], 32'h0);
        `CHK("ro_wr_err", 1'b0, e)
        for (int p = 0; p < NUM_PHASES; p++) begin
            rdc(FUND_REAL_POS_OFS[p], 32'h5, "real_pos");
            rdc(FUND_REAL_NEG_OFS[p], 32'h7, "real_neg");
        end
        chkf(32'h0);
        repeat (2) dsp(32'h7fff_ffff, 32'h0, 32'h0, 32'h0);
        rdc(FUND_REAL_POS_OFS[1], 32'h3, "pos_wrap");
        `CHK("used", 33'h0_ffff_fffe, host_model_i.used(32'h5, q, 1'b1))
        chkf(32'h1);
        repeat (2) dsp(32'h8000_0000, 32'h0, 32'h0, 32'h0);
        rdc(FUND_REAL_NEG_OFS[2], 32'h7, "neg_wrap");
        chkf(32'h3);
        repeat (3) dsp(32'h0, 32'h7fff_ffff, 32'h0, 32'h0);
        chkf(32'h7);
        repeat (2) dsp(32'h0, 32'h8000_0000, 32'h0, 32'h0);
        chkf(32'hf);
        low_power <= 1'b1;
        repeat (2) dsp(32'h0, 32'h0, 32'hffff_ffff, 32'h0);
        chkf(32'hf);
        repeat (2) dsp(32'h0, 32'h0, 32'h0, 32'h8000_0000);
        low_power <= 1'b0;
        dsp(32'h0, 32'h0, 32'h0, 32'h0);
        chkf(32'h1f);
        host_model_i.clear_flags(0, 8'h01);
        rdc(FUND_OVF_FLAGS_OFS[0], 32'h1e, "flag_clr");
        host_model_i.clear_flags(0, 8'hff);
        rdc(FUND_OVF_FLAGS_OFS[0], 32'h0, "flag_all");
        rdc(FUND_OVF_FLAGS_OFS[1], 32'h1f, "flag_kept");
        form <= 1'b1;
        ccur(32'd100);
        wrr(LOW_RANGE_OFFSET_OFS[0], 32'h0000_fffd);
        rdc(LOW_RANGE_OFFSET_OFS[0], 32'h0000_fffd, "offs_rw");
        ccur(32'd97);
        wrr(LOW_RANGE_GAIN_OFS[0], 32'h8000);
        ccur(32'd194);
        meas[0] <= '{32'd100, 1'b0};
        meas[1] <= '{32'd100, 1'b0};
        ccur(32'd100);
        `CHK("corr_b", 32'd100, corr[1])
        meas[0] <= '{32'd768, 1'b1};
        form <= 1'b0;
        wrr(LOW_RANGE_OFFSET_OFS[0], 32'h10);
        ccur(32'd2560);
        @(posedge clk_in);
        aux_valid <= 1'b1;
        aux_rms <= 32'h1234_5678;
        @(posedge clk_in);
        aux_valid <= 1'b0;
        rdc(AUX_RMS_RESULT_OFS, 32'h1234_5678, "aux_rms");
        close_out();
    end

    // Whole sequence needs under two hundred cycles
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end
endmodule : fund_energy_regs_test
`default_nettype wire
